/* test/ebu_bus_memory.sv */
// Behavioural external memory standing on the far side of the bus unit.
`timescale 1ns/1ps
module ebu_bus_memory (
	input wire logic i_clk, // Core clock.
	input wire logic i_muxed, // Address arrives over the shared port.
	input wire logic [3:0] i_wait, // Not-ready cycles per strobe.
	input wire logic [15:0] i_bus, // Resolved shared port level.
	input wire logic [15:0] i_addr_port, // Address port level.
	input wire logic i_ale, // Address latch strobe.
	input wire logic i_rd_n, // Read strobe.
	input wire logic i_wrl_n, // Low write strobe.
	input wire logic i_wrh_n, // High byte enable.
	input wire logic [4:0] i_cs_n, // Chip selects.
	output logic [15:0] o_data, // Level the memory puts on the port.
	output logic o_ready // Ready pin, high while not ready.
);
	logic [15:0] mem [16];
	logic [3:0] latched = 4'h0;
	logic [3:0] cnt = 4'h0;
	logic [15:0] last = 16'h0;
	wire [3:0] idx = i_muxed ? latched : i_addr_port[4:1];
	wire sel = i_cs_n != 5'h1f;
	wire strobe = !i_rd_n || !i_wrl_n;
	// The latch captures while the strobe is high, ahead of the edge that swaps address for data.
	always @(posedge i_clk) begin
		if (i_ale) latched <= i_bus[4:1];
		cnt <= strobe ? (cnt < i_wait ? cnt + 4'h1 : cnt) : 4'h0;
		if (!i_wrl_n && sel) begin
			mem[idx][7:0] <= i_bus[7:0];
			if (!i_wrh_n) mem[idx][15:8] <= i_bus[15:8];
		end
		if (!i_rd_n && sel) last <= mem[idx];
	end
	// Released lines show the inverse of the last value, never a stale copy.
	assign o_data = (!i_rd_n && sel) ? mem[idx] : ~last;
	// Ready floats high through its pull-up; a selected memory holds it until its count is done.
	assign o_ready = !(sel && cnt >= i_wait);
endmodule

/* test/ebu_external_bus_unit_test.sv */
// Self-checking bench for the external bus unit with a memory on the far side.
`timescale 1ns/1ps
module ebu_external_bus_unit_test;
	logic clk = 1'h0;
	logic reset_n = 1'h0;
	logic req = 1'h0, wr = 1'h0, single_chip = 1'h0, unlatched = 1'h0, wr_mode = 1'h0;
	logic arb = 1'h0, slave = 1'h0, hold_n = 1'h1, hold_ack_in_n = 1'h1, muxed = 1'h0;
	logic [23:0] addr = 24'h0;
	logic [1:0] byte_en = 2'h3, space = 2'h0;
	logic [15:0] wdata = 16'h0, dflt = 16'h0;
	logic [3:0][15:0] range = '0, wcfg = '0;
	logic [3:0] mem_wait = 4'h0;
	wire ack, dmx_oe, ale, rd_n, wrl_n, wrh_n, ctrl_oe, ready, hold_ack_n, hold_ack_oe;
	wire bus_request_out_n, bus_request_out_oe;
	wire [15:0] rdata, bus_out, dmx, mem_data;
	wire [1:0] bus_oe;
	wire [7:0] seg, seg_oe;
	wire [4:0] cs_n;
	wire [15:0] bus = {bus_oe[1] ? bus_out[15:8] : mem_data[15:8],
		bus_oe[0] ? bus_out[7:0] : mem_data[7:0]};
	int error_cnt = 0, samples_checked = 0, ack_cnt = 0, cycles = 0, lat, base;
	logic [4:0] cs_acc;
	logic [7:0] seg_or;
	logic ale_seen, wrl_seen;
	logic [15:0] ale_word, dmx_word;

	ebu_external_bus_unit dut (.i_clk(clk), .i_reset_n(reset_n), .i_req(req), .i_wr(wr),
		.i_addr(addr), .i_byte_en(byte_en), .i_wdata(wdata), .o_ack(ack), .o_rdata(rdata),
		.i_single_chip(single_chip), .i_addr_space(space), .i_window_range_select(range),
		.i_window_bus_config(wcfg), .i_default_bus_config(dflt),
		.i_unlatched_select_enable(unlatched), .i_write_strobe_mode(wr_mode),
		.i_arbitration_enable(arb), .i_port6_direction_bit7(slave), .i_mux_bus_port(bus),
		.o_mux_bus_port(bus_out), .o_mux_bus_oe(bus_oe), .o_demux_address_port(dmx),
		.o_demux_oe(dmx_oe), .o_segment_addr(seg), .o_segment_oe(seg_oe), .o_ale(ale),
		.o_rd_n(rd_n), .o_write_strobe_low_n(wrl_n), .o_write_high_n(wrh_n),
		.o_chip_select_n(cs_n), .o_ctrl_oe(ctrl_oe), .i_ready(ready), .i_hold_n(hold_n),
		.i_hold_ack_n(hold_ack_in_n), .o_hold_ack_n(hold_ack_n), .o_hold_ack_oe(hold_ack_oe),
		.o_bus_request_out_n(bus_request_out_n), .o_bus_request_oe(bus_request_out_oe));
	ebu_bus_memory mem (.i_clk(clk), .i_muxed(muxed), .i_wait(mem_wait), .i_bus(bus),
		.i_addr_port(dmx), .i_ale(ale), .i_rd_n(rd_n), .i_wrl_n(wrl_n), .i_wrh_n(wrh_n),
		.i_cs_n(cs_n), .o_data(mem_data), .o_ready(ready));

	always #4 clk = ~clk;

	////////////////////////////////////////////////////////////////////////////////
	// What the pins did during the current access.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (ack === 1'h1) ack_cnt <= ack_cnt + 1;
		if (req) begin
			cs_acc <= cs_acc & cs_n;
			seg_or <= seg_or | seg_oe;
			ale_seen <= ale_seen | ale;
			wrl_seen <= wrl_seen | ~wrl_n;
			if (ale === 1'h1) ale_word <= bus_out;
			if (dmx_oe === 1'h1) dmx_word <= dmx;
		end
		if (cycles == 20000) begin
			error_cnt = error_cnt + 1;
			wrap_up();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic start(input logic w, input logic [23:0] a, input logic [1:0] be,
		input logic [15:0] d);
		@(negedge clk);
		{wr, addr, byte_en, wdata} = {w, a, be, d};
		{cs_acc, seg_or, ale_seen, wrl_seen, ale_word, dmx_word} = {5'h1f, 8'h0, 2'h0, 32'hffffffff};
		req = 1'h1;
	endtask

	task automatic wait_ack();
		lat = 0;
		do begin
			@(negedge clk);
			lat++;
		end while (ack !== 1'h1 && lat < 200);
		check(ack, 1'h1);
		req = 1'h0;
		repeat (2) @(negedge clk);
	endtask

	task automatic access(input logic w, input logic [23:0] a, input logic [1:0] be,
		input logic [15:0] d);
		start(w, a, be, d);
		wait_ack();
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_demux();
		logic [7:0] seg_exp [4] = '{8'hff, 8'h0f, 8'h03, 8'h00};
		access(1'h1, 24'h000104, 2'h3, 16'ha5c3);
		check(cs_acc, 5'h1e);
		check(dmx_word, 16'h0104);
		for (int k = 0; k < 4; k++) begin
			space = k[1:0];
			access(1'h0, 24'h000104, 2'h3, 16'h0);
			check(rdata, 16'ha5c3);
			check(seg_or, seg_exp[k]);
		end
		space = 2'h0;
	endtask

	task automatic t_timing();
		logic [15:0] cfg [6] = '{16'h0002, 16'h0007, 16'h0020, 16'h0040, 16'h0062, 16'h0010};
		int extra [6] = '{2, 7, 1, 1, 4, 0};
		access(1'h0, 24'h000104, 2'h3, 16'h0);
		base = lat;
		for (int k = 0; k < 6; k++) begin
			dflt = cfg[k];
			access(1'h0, 24'h000104, 2'h3, 16'h0);
			check(lat - base, extra[k]);
		end
		mem_wait = 4'h4;
		dflt = 16'h0000;
		access(1'h0, 24'h000104, 2'h3, 16'h0);
		check(lat, base);
		dflt = 16'h0200;
		access(1'h0, 24'h000104, 2'h3, 16'h0);
		check(lat > base, 1'h1);
		check(rdata, 16'ha5c3);
		{mem_wait, dflt} = {4'h0, 16'h0};
	endtask

	task automatic t_windows();
		logic [4:0] cs_exp [4] = '{5'h1d, 5'h1b, 5'h17, 5'h0f};
		range = {16'h0200, 16'h0200, 16'h0100, 16'h0100};
		muxed = 1'h1;
		for (int k = 0; k < 4; k++) begin
			wcfg[k] = 16'h0480;
			unlatched = (k == 3);
			access(1'h1, {k < 2 ? 8'h01 : 8'h02, 16'h0008}, 2'h3, 16'h3c5a);
			check(cs_acc, cs_exp[k]);
			check(ale_seen, 1'h1);
			check(ale_word, 16'h0008);
			access(1'h0, {k < 2 ? 8'h01 : 8'h02, 16'h0008}, 2'h3, 16'h0);
			check(rdata, 16'h3c5a);
		end
		wcfg[3] = 16'h0500;
		access(1'h0, 24'h020008, 2'h3, 16'h0);
		check(rdata, 16'h5a5a);
		{wcfg, muxed, unlatched} = '0;
	endtask

	task automatic t_strobe();
		logic [2:0] mode_be [4] = '{3'b110, 3'b101, 3'b010, 3'b110};
		logic seen_exp [4] = '{1'h0, 1'h1, 1'h1, 1'h1};
		for (int k = 0; k < 4; k++) begin
			wr_mode = mode_be[k][2];
			dflt = (k == 3) ? 16'h0180 : 16'h0000;
			access(1'h1, 24'h000180, mode_be[k][1:0], 16'h1234);
			check(wrl_seen, seen_exp[k]);
		end
		{wr_mode, dflt} = {1'h0, 16'h0000};
	endtask

	task automatic t_arbitration();
		int n;
		arb = 1'h1;
		repeat (4) @(negedge clk);
		check(hold_ack_oe, 1'h1);
		hold_n = 1'h0;
		repeat (6) @(negedge clk);
		check({hold_ack_n, bus_oe, ctrl_oe}, 4'h0);
		n = ack_cnt;
		start(1'h0, 24'h000104, 2'h3, 16'h0);
		repeat (8) @(negedge clk);
		check(ack_cnt - n, 0);
		check({bus_request_out_n, bus_request_out_oe}, 2'b01);
		hold_n = 1'h1;
		wait_ack();
		check(rdata, 16'ha5c3);
		slave = 1'h1;
		repeat (4) @(negedge clk);
		check(hold_ack_oe, 1'h0);
		n = ack_cnt;
		start(1'h0, 24'h000104, 2'h3, 16'h0);
		repeat (8) @(negedge clk);
		check(ack_cnt - n, 0);
		check({bus_request_out_n, bus_request_out_oe}, 2'b01);
		hold_ack_in_n = 1'h0;
		wait_ack();
		check(rdata, 16'ha5c3);
		{slave, hold_ack_in_n, arb} = 3'b010;
	endtask

	task automatic t_single_chip();
		int n;
		single_chip = 1'h1;
		n = ack_cnt;
		start(1'h0, 24'h000104, 2'h3, 16'h0);
		repeat (20) @(negedge clk);
		check(ack_cnt - n, 0);
		req = 1'h0;
		single_chip = 1'h0;
		repeat (2) @(negedge clk);
	endtask

	task automatic wrap_up();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		repeat (3) @(negedge clk);
		check({bus_oe, dmx_oe, seg_oe, ctrl_oe, hold_ack_oe, bus_request_out_oe}, 15'h0);
		reset_n = 1'h1;
		t_demux();
		t_timing();
		t_windows();
		t_strobe();
		t_arbitration();
		t_single_chip();
		wrap_up();
	end
endmodule

/* verilog/ebu_cfg.svh */
// Constants, field positions and segment masks of the external bus unit.
`ifndef EBU_CFG_SVH
`define EBU_CFG_SVH

// Bus configuration word fields.
`define EBU_CFG_WAIT_LSB 0
`define EBU_CFG_WAIT_MSB 3
`define EBU_CFG_TRISTATE 4
`define EBU_CFG_ALE_LONG 5
`define EBU_CFG_RW_DELAY 6
`define EBU_CFG_MODE_LSB 7
`define EBU_CFG_MODE_MSB 8
`define EBU_CFG_READY_EN 9
`define EBU_CFG_WIN_EN 10

// Window range word fields: base is address bits 23..12, size code gives 4K << code.
`define EBU_RANGE_BASE_LSB 4
`define EBU_RANGE_BASE_MSB 15
`define EBU_RANGE_SIZE_LSB 0
`define EBU_RANGE_SIZE_MSB 3

// Cycles the pin samples need to cross the two-stage synchroniser before capture.
`define EBU_SYNC_CYCLES 4'h3
`define EBU_ALE_LONG_CYCLES 4'h1

// Address space codes and segment line masks.
`define EBU_SPACE_16M 2'h0
`define EBU_SPACE_1M 2'h1
`define EBU_SPACE_256K 2'h2
`define EBU_SPACE_64K 2'h3
`define EBU_SEG_MASK_16M 8'hff
`define EBU_SEG_MASK_1M 8'h0f
`define EBU_SEG_MASK_256K 8'h03
`define EBU_SEG_MASK_64K 8'h00

`endif

/* verilog/ebu_external_bus_unit.sv */
// External bus unit: sequences off-chip accesses, chip selects and bus arbitration.
`timescale 1ns/1ps
`include "ebu_cfg.svh"
module ebu_external_bus_unit (
	input wire logic i_clk, // Core clock, 125 MHz.
	input wire logic i_reset_n, // Asynchronous reset, active low.
	input wire logic i_req, // Access request, level, held until o_ack.
	input wire logic i_wr, // Request is a write.
	input wire logic [23:0] i_addr, // Request byte address.
	input wire logic [1:0] i_byte_en, // Byte lanes, bit 0 low byte.
	input wire logic [15:0] i_wdata, // Write data.
	output logic o_ack, // One-cycle pulse when the access ends.
	output logic [15:0] o_rdata, // Read data, valid with o_ack.
	input wire logic i_single_chip, // No external accesses at all.
	input wire logic [1:0] i_addr_space, // Segment address space code.
	input wire logic [3:0][15:0] i_window_range_select, // Window range words.
	input wire logic [3:0][15:0] i_window_bus_config, // Window bus configurations.
	input wire logic [15:0] i_default_bus_config, // Default bus configuration.
	input wire logic i_unlatched_select_enable, // Chip selects follow the address.
	input wire logic i_write_strobe_mode, // Low write strobe only for low-byte writes on a 16-bit bus; 8-bit modes strobe every write.
	input wire logic i_arbitration_enable, // Hand arbitration pins to the unit.
	input wire logic i_port6_direction_bit7, // Set selects slave mode.
	input wire logic [15:0] i_mux_bus_port, // Shared bus port pin levels.
	output logic [15:0] o_mux_bus_port, // Shared bus port drive value.
	output logic [1:0] o_mux_bus_oe, // Shared bus port enables, per byte.
	output logic [15:0] o_demux_address_port, // Address port value.
	output logic o_demux_oe, // Address port enable.
	output logic [7:0] o_segment_addr, // Segment address lines 23..16.
	output logic [7:0] o_segment_oe, // Segment line enables.
	output logic o_ale, // Address latch strobe, active high.
	output logic o_rd_n, // Read strobe.
	output logic o_write_strobe_low_n, // Low write strobe.
	output logic o_write_high_n, // High-byte write strobe or byte enable.
	output logic [4:0] o_chip_select_n, // Chip selects, bit 0 default region.
	output logic o_ctrl_oe, // Enable for strobes and chip selects.
	input wire logic i_ready, // Ready pin, high lengthens the access.
	input wire logic i_hold_n, // Hold request pin.
	input wire logic i_hold_ack_n, // Hold acknowledge pin level, slave mode.
	output logic o_hold_ack_n, // Hold acknowledge drive value.
	output logic o_hold_ack_oe, // Hold acknowledge enable.
	output logic o_bus_request_out_n, // Bus request drive value.
	output logic o_bus_request_oe // Bus request enable.
);
	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers.
	logic [1:0] ready_sync;
	logic [1:0] hold_sync;
	logic [1:0] hold_acknowledge_sync;
	logic [15:0] data_meta;
	logic [15:0] data_sync;

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ready_sync <= 2'h0;
			hold_sync <= 2'h3;
			hold_acknowledge_sync <= 2'h3;
			data_meta <= 16'h0000;
			data_sync <= 16'h0000;
		end else begin
			ready_sync <= {ready_sync[0], i_ready};
			hold_sync <= {hold_sync[0], i_hold_n};
			hold_acknowledge_sync <= {hold_acknowledge_sync[0], i_hold_ack_n};
			data_meta <= i_mux_bus_port;
			data_sync <= data_meta;
		end
	end

	wire ready_busy = ready_sync[1];
	wire hold_req = ~hold_sync[1];
	wire slave_mode = i_port6_direction_bit7;
	wire granted_in = ~hold_acknowledge_sync[1];

	////////////////////////////////////////////////////////////////////////////////
	// Window decode of the live request address; the access in flight keeps its captured result.
	logic [15:0] win_cfg;
	logic [4:0] win_select;

	ebu_window_decode u_decode (
		.i_addr(i_addr),
		.i_window_range_select(i_window_range_select),
		.i_window_bus_config(i_window_bus_config),
		.i_default_bus_config(i_default_bus_config),
		.o_cfg(win_cfg),
		.o_select(win_select)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Access sequencer.
	ebu_pkg::ebu_state_e state;
	logic [3:0] cnt;
	logic [23:0] acc_addr;
	logic acc_wr;
	logic [1:0] acc_be;
	logic [15:0] acc_wdata;
	logic [15:0] acc_cfg;
	logic [4:0] acc_select;

	ebu_pkg::ebu_bus_mode_e acc_mode;
	assign acc_mode = ebu_pkg::ebu_bus_mode_e'(acc_cfg[`EBU_CFG_MODE_MSB:`EBU_CFG_MODE_LSB]);
	wire acc_mux = (acc_mode == ebu_pkg::EBU_MUX16) || (acc_mode == ebu_pkg::EBU_MUX8);
	wire acc_bus8 = (acc_mode == ebu_pkg::EBU_MUX8) || (acc_mode == ebu_pkg::EBU_DEMUX8);
	wire owned = slave_mode ? granted_in : (state != ebu_pkg::EBU_HOLD);
	wire in_access = (state != ebu_pkg::EBU_IDLE) && (state != ebu_pkg::EBU_HOLD);
	wire data_phase = (state == ebu_pkg::EBU_STROBE) || (state == ebu_pkg::EBU_FINISH);
	wire want_bus = i_req && !i_single_chip && !o_ack;

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state <= ebu_pkg::EBU_IDLE;
			cnt <= 4'h0;
			acc_addr <= 24'h000000;
			acc_wr <= 1'b0;
			acc_be <= 2'h0;
			acc_wdata <= 16'h0000;
			acc_cfg <= 16'h0000;
			acc_select <= 5'h00;
			o_ack <= 1'b0;
			o_rdata <= 16'h0000;
		end else begin
			o_ack <= 1'b0;
			unique case (state)
				ebu_pkg::EBU_IDLE: begin
					if (i_arbitration_enable && !slave_mode && hold_req) begin
						state <= ebu_pkg::EBU_HOLD;
					end else if (want_bus && owned) begin
						acc_addr <= i_addr;
						acc_wr <= i_wr;
						acc_be <= i_byte_en;
						acc_wdata <= i_wdata;
						acc_cfg <= win_cfg;
						acc_select <= win_select;
						cnt <= win_cfg[`EBU_CFG_ALE_LONG] ? `EBU_ALE_LONG_CYCLES : 4'h0;
						state <= ebu_pkg::EBU_ADDR;
					end
				end
				ebu_pkg::EBU_ADDR: begin
					if (cnt != 4'h0) begin
						cnt <= cnt - 4'h1;
					end else begin
						cnt <= acc_cfg[`EBU_CFG_WAIT_MSB:`EBU_CFG_WAIT_LSB];
						state <= acc_cfg[`EBU_CFG_RW_DELAY] ? ebu_pkg::EBU_DELAY
							: ebu_pkg::EBU_STROBE;
					end
				end
				ebu_pkg::EBU_DELAY: begin
					state <= ebu_pkg::EBU_STROBE;
				end
				ebu_pkg::EBU_STROBE: begin
					if (cnt != 4'h0) begin
						cnt <= cnt - 4'h1;
					end else if (!(acc_cfg[`EBU_CFG_READY_EN] && ready_busy)) begin
						cnt <= `EBU_SYNC_CYCLES;
						state <= ebu_pkg::EBU_FINISH;
					end
				end
				ebu_pkg::EBU_FINISH: begin
					if (cnt != 4'h0) begin
						cnt <= cnt - 4'h1;
					end else begin
						o_ack <= 1'b1;
						o_rdata <= acc_bus8 ? {data_sync[7:0], data_sync[7:0]} : data_sync;
						state <= acc_cfg[`EBU_CFG_TRISTATE] ? ebu_pkg::EBU_RECOVER
							: ebu_pkg::EBU_IDLE;
					end
				end
				ebu_pkg::EBU_RECOVER: begin
					state <= ebu_pkg::EBU_IDLE;
				end
				ebu_pkg::EBU_HOLD: begin
					if (!hold_req || !i_arbitration_enable) begin
						state <= ebu_pkg::EBU_IDLE;
					end
				end
				default: begin
					state <= ebu_pkg::EBU_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus pins; every enable is low while reset is active.
	wire drive = owned && !i_single_chip;
	wire [7:0] byte_out = acc_be[0] ? acc_wdata[7:0] : acc_wdata[15:8];

	function automatic logic [7:0] segment_mask(input logic [1:0] space);
		unique case (space)
			`EBU_SPACE_16M: segment_mask = `EBU_SEG_MASK_16M;
			`EBU_SPACE_1M: segment_mask = `EBU_SEG_MASK_1M;
			`EBU_SPACE_256K: segment_mask = `EBU_SEG_MASK_256K;
			`EBU_SPACE_64K: segment_mask = `EBU_SEG_MASK_64K;
		endcase
	endfunction

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_mux_bus_port <= 16'h0000;
			o_mux_bus_oe <= 2'h0;
			o_demux_address_port <= 16'h0000;
			o_demux_oe <= 1'b0;
			o_segment_addr <= 8'h00;
			o_segment_oe <= 8'h00;
			o_ale <= 1'b0;
			o_rd_n <= 1'b1;
			o_write_strobe_low_n <= 1'b1;
			o_write_high_n <= 1'b1;
			o_ctrl_oe <= 1'b0;
		end else begin
			o_ctrl_oe <= drive;
			o_ale <= (state == ebu_pkg::EBU_ADDR) && acc_mux;
			o_segment_addr <= acc_addr[23:16];
			o_segment_oe <= drive ? segment_mask(i_addr_space) : 8'h00;
			o_demux_address_port <= acc_addr[15:0];
			o_demux_oe <= drive && !acc_mux && in_access;
			o_rd_n <= !(data_phase && !acc_wr);
			o_write_strobe_low_n <= !(data_phase && acc_wr &&
				(!i_write_strobe_mode || acc_bus8 || acc_be[0]));
			o_write_high_n <= !(data_phase && !acc_bus8 && acc_be[1] &&
				(acc_wr || !i_write_strobe_mode));
			if (acc_mux && !data_phase && state != ebu_pkg::EBU_RECOVER) begin
				o_mux_bus_port <= acc_addr[15:0];
				o_mux_bus_oe <= (drive && in_access) ? 2'h3 : 2'h0;
			end else begin
				o_mux_bus_port <= acc_bus8 ? {8'h00, byte_out} : acc_wdata;
				o_mux_bus_oe <= (drive && data_phase && acc_wr) ?
					(acc_bus8 ? 2'h1 : 2'h3) : 2'h0;
			end
		end
	end

	// Chip selects: latched mode holds the access's select for its whole length.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_chip_select_n <= 5'h1f;
		end else if (i_unlatched_select_enable) begin
			o_chip_select_n <= in_access ? ~acc_select
				: (want_bus && drive ? ~win_select : 5'h1f);
		end else begin
			o_chip_select_n <= in_access ? ~acc_select : 5'h1f;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Arbitration pins.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_hold_ack_n <= 1'b1;
			o_hold_ack_oe <= 1'b0;
			o_bus_request_out_n <= 1'b1;
			o_bus_request_oe <= 1'b0;
		end else begin
			o_hold_ack_oe <= i_arbitration_enable && !slave_mode;
			o_hold_ack_n <= !(state == ebu_pkg::EBU_HOLD);
			o_bus_request_oe <= i_arbitration_enable;
			o_bus_request_out_n <= !(i_arbitration_enable && want_bus && !owned);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks.
	a_select_onehot: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		$countones(~o_chip_select_n) <= 1)
		else $error("more than one chip select active");

	a_hold_floats: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(state == ebu_pkg::EBU_HOLD) |=> (o_mux_bus_oe == 2'h0) && !o_ctrl_oe && !o_demux_oe)
		else $error("bus driven while held");

	a_single_idle: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(state == ebu_pkg::EBU_IDLE) && i_single_chip |=> state != ebu_pkg::EBU_ADDR)
		else $error("external access in single-chip mode");

	a_ale_addr: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		o_ale |-> $past(state) == ebu_pkg::EBU_ADDR && o_mux_bus_port == acc_addr[15:0])
		else $error("latch strobe outside address phase");

	a_ready_wait: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(state == ebu_pkg::EBU_STROBE) && cnt == 4'h0 && acc_cfg[`EBU_CFG_READY_EN] &&
		ready_busy |=> state == ebu_pkg::EBU_STROBE)
		else $error("ready high did not hold the strobe");

	a_wait_load: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(state != ebu_pkg::EBU_STROBE) ##1 (state == ebu_pkg::EBU_STROBE) |->
		cnt == acc_cfg[`EBU_CFG_WAIT_MSB:`EBU_CFG_WAIT_LSB])
		else $error("wait-state count not loaded");

	a_request_held: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		i_arbitration_enable && want_bus && !owned |=> !o_bus_request_out_n)
		else $error("bus request missing while bus is away");

	a_space_64k: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		i_addr_space == `EBU_SPACE_64K |=> o_segment_oe == 8'h00)
		else $error("segment line driven in 64K space");

	a_slave_input: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		slave_mode |=> !o_hold_ack_oe)
		else $error("acknowledge driven in slave mode");

	a_strobe_low: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		!o_write_strobe_low_n && i_write_strobe_mode && !acc_bus8 |-> acc_be[0] && acc_wr)
		else $error("low write strobe on high-byte write");
endmodule

/* verilog/ebu_pkg.sv */
// Types shared by the external bus unit modules.
package ebu_pkg;
	typedef enum logic [1:0] {
		EBU_DEMUX16 = 2'b00,
		EBU_MUX16 = 2'b01,
		EBU_MUX8 = 2'b10,
		EBU_DEMUX8 = 2'b11
	} ebu_bus_mode_e;

	typedef enum logic [2:0] {
		EBU_IDLE = 3'b000,
		EBU_ADDR = 3'b001,
		EBU_DELAY = 3'b010,
		EBU_STROBE = 3'b011,
		EBU_FINISH = 3'b100,
		EBU_RECOVER = 3'b101,
		EBU_HOLD = 3'b110
	} ebu_state_e;

	typedef logic [15:0] ebu_word_t;
endpackage

/* verilog/ebu_window_decode.sv */
// Address window decoder: picks the bus configuration and chip select of an address.
`timescale 1ns/1ps
`include "ebu_cfg.svh"
module ebu_window_decode (
	input wire logic [23:0] i_addr, // Address to decode.
	input wire logic [3:0][15:0] i_window_range_select, // Range words, windows 1..4.
	input wire logic [3:0][15:0] i_window_bus_config, // Bus configs, windows 1..4.
	input wire logic [15:0] i_default_bus_config, // Config outside all windows.
	output logic [15:0] o_cfg, // Selected bus configuration.
	output logic [4:0] o_select // One-hot region, bit 0 default.
);
	function automatic logic window_hit(input logic [23:0] addr, input logic [15:0] range);
		logic [11:0] mask;
		mask = 12'hfff << range[`EBU_RANGE_SIZE_MSB:`EBU_RANGE_SIZE_LSB];
		window_hit = ((addr[23:12] ^ range[`EBU_RANGE_BASE_MSB:`EBU_RANGE_BASE_LSB]) & mask)
			== 12'h000;
	endfunction

	logic [3:0] hit;

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_win
			assign hit[g] = i_window_bus_config[g][`EBU_CFG_WIN_EN] &&
				window_hit(i_addr, i_window_range_select[g]);
		end
	endgenerate

	always_comb begin
		o_cfg = i_default_bus_config;
		o_select = 5'h01;
		if (hit[3]) begin
			o_cfg = i_window_bus_config[3];
			o_select = 5'h10;
		end else if (hit[2]) begin
			o_cfg = i_window_bus_config[2];
			o_select = 5'h08;
		end else if (hit[1]) begin
			o_cfg = i_window_bus_config[1];
			o_select = 5'h04;
		end else if (hit[0]) begin
			o_cfg = i_window_bus_config[0];
			o_select = 5'h02;
		end
	end
endmodule
